// ===== pkg/rmsl_pkg.sv
// Purpose: Shared constants for the radio modem serial link controller
// Assumes: 100 MHz system clock, word-indexed register port
// Notes:   Register addresses are word indices on the plain register port
package rmsl_pkg;

    localparam int          ADDR_W          = 6;
    localparam int          DATA_W          = 16;

    // Timing
    localparam int          CLK_HZ          = 100_000_000;
    localparam int          PRE_STEP_MS     = 1;
    localparam int          RTS_STEP_MS     = 20;
    localparam int          PRE_STEP_CYC    = CLK_HZ / 1000 * PRE_STEP_MS;
    localparam int          RTS_STEP_CYC    = CLK_HZ / 1000 * RTS_STEP_MS;
    localparam int          BAUD_DEFAULT    = 19200;
    localparam logic [15:0] BAUD_DIV_RST    = 16'(CLK_HZ / BAUD_DEFAULT);

    // Register indices
    localparam logic [5:0]  REG_CONFIG      = 6'h00;
    localparam logic [5:0]  REG_NODE_ADDR   = 6'h01;
    localparam logic [5:0]  REG_BAUD_DIV    = 6'h02;
    localparam logic [5:0]  REG_FWD_FILE    = 6'h03;
    localparam logic [5:0]  REG_PRE_DELAY   = 6'h04;
    localparam logic [5:0]  REG_RTS_ON      = 6'h05;
    localparam logic [5:0]  REG_RTS_OFF     = 6'h06;
    localparam logic [5:0]  REG_INT_STATUS  = 6'h07;
    localparam logic [5:0]  REG_INT_MASK    = 6'h08;
    localparam logic [5:0]  REG_LINE_STATUS = 6'h09;
    localparam logic [5:0]  REG_UNDELIVERED = 6'h0C;
    localparam logic [5:0]  REG_RETRY_SENT  = 6'h0D;
    localparam logic [5:0]  REG_BAD_PACKET  = 6'h10;
    localparam logic [5:0]  REG_DUPLICATE   = 6'h12;
    localparam logic [5:0]  REG_FWD_TABLE   = 6'h20;

    // Config fields
    localparam int          CFG_PARITY_BIT  = 0;
    localparam int          CFG_CRC_BIT     = 1;
    localparam int          CFG_MODE_LSB    = 2;
    localparam logic [15:0] CONFIG_RST      = 16'h0002;

    // Control line modes
    localparam logic [1:0]  MODE_NONE       = 2'h0;
    localparam logic [1:0]  MODE_RTS_CTS    = 2'h1;
    localparam logic [1:0]  MODE_DCD        = 2'h2;

    // Line status bits
    localparam int          LS_CTS_BIT      = 0;
    localparam int          LS_RTS_BIT      = 1;
    localparam int          LS_DCD_BIT      = 3;

    // Interrupt status bits
    localparam int          INT_BAD_BIT     = 0;
    localparam int          INT_DUP_BIT     = 1;
    localparam int          INT_UNDEL_BIT   = 2;
    localparam int          INT_RETRY_BIT   = 3;
    localparam int          INT_W           = 4;

    // Addresses and checks
    localparam logic [7:0]  NODE_ADDR_RST   = 8'h01;
    localparam logic [7:0]  BROADCAST_ADDR  = 8'hFF;
    localparam logic [7:0]  FWD_FILE_MIN    = 8'h09;
    localparam logic [15:0] CRC_POLY        = 16'hA001;
    localparam logic [15:0] SIG_SEED        = 16'hFFFF;
    localparam logic [3:0]  HDR_BYTES       = 4'h2;

    typedef enum {
        ST_IDLE,
        ST_PRE,
        ST_RTS_ON,
        ST_SEND,
        ST_RTS_OFF
    } rmsl_state_t;

endpackage

// ===== src/rmsl_link.sv
// Purpose: Radio modem link layer: handshake timing, packet checks, counters
// Assumes: External UART delivers bytes and takes baud/parity settings
// Notes:   Packet bytes are DST, SRC, body, then check bytes
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
module rmsl_link
    import rmsl_pkg::*;
#(
    parameter int PRE_CYC = PRE_STEP_CYC,
    parameter int RTS_CYC = RTS_STEP_CYC,
    parameter bit HAS_DCD = 1'b1
) (
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    input  wire logic [rmsl_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [rmsl_pkg::DATA_W-1:0] regWrData,
    input  wire logic                       regWrStrobe,
    input  wire logic                       regRdStrobe,
    output logic      [rmsl_pkg::DATA_W-1:0] regRdData,
    output logic                            irq,
    input  wire logic                       ctsIn,
    input  wire logic                       dcdIn,
    output logic                            rtsOut,
    output logic      [15:0]                baudDiv,
    output logic                            parityEven,
    input  wire logic                       txReq,
    input  wire logic                       txRetry,
    output logic                            txGo,
    input  wire logic                       txDone,
    input  wire logic                       txNoAck,
    input  wire logic [7:0]                 rxByte,
    input  wire logic                       rxValid,
    input  wire logic                       rxParErr,
    input  wire logic                       rxEnd,
    output logic                            rxAck,
    output logic                            rxDeliver,
    output logic                            rxForward
);
    import rmsl_pkg::*;

    generate
        if (PRE_CYC < 1 || RTS_CYC < 1) begin : g_bad_step
            $error("Step lengths must be at least one cycle");
        end
    endgenerate

    function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] v;
        v = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            v = v[0] ? ((v >> 1) ^ CRC_POLY) : (v >> 1);
        end
        return v;
    endfunction

    // Configuration, status and counter registers
    logic [15:0]    config_r;
    logic [7:0]     nodeAddr_r;
    logic [15:0]    baudDiv_r;
    logic [7:0]     fwdFile_r;
    logic [7:0]     preDelay_r;
    logic [7:0]     rtsOnDelay_r;
    logic [7:0]     rtsOffDelay_r;
    logic [255:0]   fwdTable_r;
    logic [INT_W-1:0] intStatus_r;
    logic [INT_W-1:0] intMask_r;
    logic [15:0]    undelCnt_r;
    logic [15:0]    retryCnt_r;
    logic [15:0]    badCnt_r;
    logic [15:0]    dupCnt_r;
    logic [15:0]    rdData_r;

    logic [1:0]     mode;
    logic           crcSel;
    logic           fwdEnable;
    logic           wrHit;

    assign mode      = config_r[CFG_MODE_LSB +: 2];
    assign crcSel    = config_r[CFG_CRC_BIT];
    assign fwdEnable = (fwdFile_r != 8'h00);
    assign wrHit     = regWrStrobe;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            config_r      <= CONFIG_RST;
            nodeAddr_r    <= NODE_ADDR_RST;
            baudDiv_r     <= BAUD_DIV_RST;
            fwdFile_r     <= 8'h00;
            preDelay_r    <= 8'h00;
            rtsOnDelay_r  <= 8'h00;
            rtsOffDelay_r <= 8'h00;
            intMask_r     <= '0;
            fwdTable_r    <= '0;
        end else if (wrHit) begin
            case (regAddr)
                REG_CONFIG: begin
                    config_r <= {12'h000, regWrData[3:0]};
                end
                REG_NODE_ADDR: begin
                    if (regWrData[7:0] != BROADCAST_ADDR) begin
                        nodeAddr_r <= regWrData[7:0];
                    end
                end
                REG_BAUD_DIV: begin
                    if (regWrData != 16'h0000) begin
                        baudDiv_r <= regWrData;
                    end
                end
                REG_FWD_FILE: begin
                    if (regWrData[7:0] == 8'h00 || regWrData[7:0] >= FWD_FILE_MIN) begin
                        fwdFile_r <= regWrData[7:0];
                    end
                end
                REG_PRE_DELAY: preDelay_r    <= regWrData[7:0];
                REG_RTS_ON:    rtsOnDelay_r  <= regWrData[7:0];
                REG_RTS_OFF:   rtsOffDelay_r <= regWrData[7:0];
                REG_INT_MASK:  intMask_r     <= regWrData[INT_W-1:0];
                default: begin
                    if (regAddr[5:4] == REG_FWD_TABLE[5:4]) begin
                        fwdTable_r[{regAddr[3:0], 4'h0} +: 16] <= regWrData;
                    end
                end
            endcase
        end
    end

    assign baudDiv    = baudDiv_r;
    assign parityEven = config_r[CFG_PARITY_BIT];

    // Handshake line synchronisers
    logic [2:0]     ctsSync_r;
    logic [2:0]     dcdSync_r;
    logic           ctsLvl_r;
    logic           dcdLvl_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctsSync_r <= 3'h0;
            dcdSync_r <= 3'h0;
            ctsLvl_r  <= 1'b0;
            dcdLvl_r  <= 1'b0;
        end else begin
            ctsSync_r <= {ctsSync_r[1:0], ctsIn};
            dcdSync_r <= {dcdSync_r[1:0], dcdIn};
            if (ctsSync_r[1] == ctsSync_r[2]) begin
                ctsLvl_r <= ctsSync_r[2];
            end
            if (dcdSync_r[1] == dcdSync_r[2]) begin
                dcdLvl_r <= dcdSync_r[2] & HAS_DCD;
            end
        end
    end

    // Transmit sequencing
    rmsl_state_t    state_r;
    rmsl_state_t    state_nxt;
    logic [31:0]    tickCnt_r;
    logic [7:0]     stepCnt_r;
    logic           rts_r;
    logic           clearOk;
    logic           stepDone;
    logic [31:0]    stepLen;
    logic           hsMode;

    assign hsMode  = (mode == MODE_RTS_CTS) || (mode == MODE_DCD);
    assign clearOk = (mode == MODE_RTS_CTS) ? ctsLvl_r :
                     (mode == MODE_DCD)     ? !dcdLvl_r : 1'b1;
    assign stepLen = (state_r == ST_PRE) ? 32'(PRE_CYC) : 32'(RTS_CYC);

    always_comb begin
        stepDone = 1'b0;
        case (state_r)
            ST_PRE:     stepDone = (stepCnt_r >= preDelay_r);
            ST_RTS_ON:  stepDone = (stepCnt_r >= rtsOnDelay_r);
            ST_RTS_OFF: stepDone = (stepCnt_r >= rtsOffDelay_r);
            default:    stepDone = 1'b0;
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (txReq) begin
                    state_nxt = ST_PRE;
                end
            end
            ST_PRE: begin
                if (stepDone) begin
                    state_nxt = hsMode ? ST_RTS_ON : ST_SEND;
                end
            end
            ST_RTS_ON: begin
                if (stepDone) begin
                    state_nxt = ST_SEND;
                end
            end
            ST_SEND: begin
                if (txDone) begin
                    state_nxt = hsMode ? ST_RTS_OFF : ST_IDLE;
                end
            end
            ST_RTS_OFF: begin
                if (stepDone) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r   <= ST_IDLE;
            tickCnt_r <= 32'h0000_0000;
            stepCnt_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            if (state_nxt != state_r) begin
                tickCnt_r <= 32'h0000_0000;
                stepCnt_r <= 8'h00;
            end else if (tickCnt_r >= stepLen - 32'h1) begin
                tickCnt_r <= 32'h0000_0000;
                if (stepCnt_r != 8'hFF) begin
                    stepCnt_r <= stepCnt_r + 8'h01;
                end
            end else begin
                tickCnt_r <= tickCnt_r + 32'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rts_r <= 1'b0;
        end else begin
            rts_r <= hsMode && (state_nxt == ST_RTS_ON || state_nxt == ST_SEND ||
                                state_nxt == ST_RTS_OFF);
        end
    end

    assign rtsOut = rts_r;
    assign txGo   = (state_r == ST_SEND) && clearOk;

    // Receive checks
    logic [15:0]    crc_r;
    logic [15:0]    sig_r;
    logic [7:0]     sum_r;
    logic [3:0]     byteIdx_r;
    logic [7:0]     dst_r;
    logic [7:0]     src_r;
    logic           parErr_r;
    logic [15:0]    prevSig_r;
    logic           prevValid_r;
    logic           chkOk;
    logic           lenOk;
    logic           pktGood;
    logic           pktBad;
    logic           pktDup;
    logic           forMe;
    logic           fwdOk;
    logic           rxAck_r;
    logic           rxDeliver_r;
    logic           rxForward_r;

    assign chkOk   = crcSel ? (crc_r == 16'h0000) : (sum_r == 8'h00);
    assign lenOk   = byteIdx_r >= (HDR_BYTES + (crcSel ? 4'h2 : 4'h1));
    assign pktGood = rxEnd && chkOk && lenOk && !parErr_r;
    assign pktBad  = rxEnd && !(chkOk && lenOk && !parErr_r);
    assign pktDup  = pktGood && prevValid_r && (sig_r == prevSig_r);
    assign forMe   = (dst_r == nodeAddr_r) || (dst_r == BROADCAST_ADDR);
    assign fwdOk   = fwdEnable && (dst_r != nodeAddr_r) && (src_r != nodeAddr_r) &&
                     fwdTable_r[dst_r] && fwdTable_r[src_r];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            crc_r     <= 16'h0000;
            sig_r     <= SIG_SEED;
            sum_r     <= 8'h00;
            byteIdx_r <= 4'h0;
            dst_r     <= 8'h00;
            src_r     <= 8'h00;
            parErr_r  <= 1'b0;
        end else if (rxEnd) begin
            crc_r     <= 16'h0000;
            sig_r     <= SIG_SEED;
            sum_r     <= 8'h00;
            byteIdx_r <= 4'h0;
            parErr_r  <= 1'b0;
        end else if (rxValid) begin
            crc_r    <= crcStep(crc_r, rxByte);
            sig_r    <= crcStep(sig_r, rxByte);
            sum_r    <= sum_r + rxByte;
            parErr_r <= parErr_r | rxParErr;
            if (byteIdx_r != 4'hF) begin
                byteIdx_r <= byteIdx_r + 4'h1;
            end
            if (byteIdx_r == 4'h0) begin
                dst_r <= rxByte;
            end
            if (byteIdx_r == 4'h1) begin
                src_r <= rxByte;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prevSig_r   <= 16'h0000;
            prevValid_r <= 1'b0;
        end else if (pktGood) begin
            prevSig_r   <= sig_r;
            prevValid_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rxAck_r     <= 1'b0;
            rxDeliver_r <= 1'b0;
            rxForward_r <= 1'b0;
        end else begin
            rxAck_r     <= pktGood && (dst_r == nodeAddr_r);
            rxDeliver_r <= pktGood && !pktDup && forMe;
            rxForward_r <= pktGood && !pktDup && fwdOk;
        end
    end

    assign rxAck     = rxAck_r;
    assign rxDeliver = rxDeliver_r;
    assign rxForward = rxForward_r;

    // Diagnostic counters
    logic           retryEv;
    assign retryEv = (state_r == ST_IDLE) && txReq && txRetry;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            undelCnt_r <= 16'h0000;
            retryCnt_r <= 16'h0000;
            badCnt_r   <= 16'h0000;
            dupCnt_r   <= 16'h0000;
        end else begin
            if (retryEv) begin
                retryCnt_r <= retryCnt_r + 16'h0001;
            end
            if (txNoAck) begin
                undelCnt_r <= undelCnt_r + 16'h0001;
            end
            if (pktBad) begin
                badCnt_r <= badCnt_r + 16'h0001;
            end
            if (pktDup) begin
                dupCnt_r <= dupCnt_r + 16'h0001;
            end
        end
    end

    // Interrupt status, set wins over clear
    logic [INT_W-1:0] intSet;
    logic [INT_W-1:0] intClr;

    always_comb begin
        intSet = '0;
        intSet[INT_BAD_BIT]   = pktBad;
        intSet[INT_DUP_BIT]   = pktDup;
        intSet[INT_UNDEL_BIT] = txNoAck;
        intSet[INT_RETRY_BIT] = retryEv;
    end

    assign intClr = (wrHit && regAddr == REG_INT_STATUS) ? regWrData[INT_W-1:0] : '0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            intStatus_r <= '0;
        end else begin
            intStatus_r <= (intStatus_r & ~intClr) | intSet;
        end
    end

    assign irq = |(intStatus_r & intMask_r);

    // Register read
    logic [15:0]    lineStatus;
    logic [15:0]    rdMux;

    always_comb begin
        lineStatus = 16'h0000;
        lineStatus[LS_CTS_BIT] = ctsLvl_r;
        lineStatus[LS_RTS_BIT] = rts_r;
        lineStatus[LS_DCD_BIT] = dcdLvl_r;
    end

    always_comb begin
        rdMux = 16'h0000;
        case (regAddr)
            REG_CONFIG:      rdMux = config_r;
            REG_NODE_ADDR:   rdMux = {8'h00, nodeAddr_r};
            REG_BAUD_DIV:    rdMux = baudDiv_r;
            REG_FWD_FILE:    rdMux = {8'h00, fwdFile_r};
            REG_PRE_DELAY:   rdMux = {8'h00, preDelay_r};
            REG_RTS_ON:      rdMux = {8'h00, rtsOnDelay_r};
            REG_RTS_OFF:     rdMux = {8'h00, rtsOffDelay_r};
            REG_INT_STATUS:  rdMux = {12'h000, intStatus_r};
            REG_INT_MASK:    rdMux = {12'h000, intMask_r};
            REG_LINE_STATUS: rdMux = lineStatus;
            REG_UNDELIVERED: rdMux = undelCnt_r;
            REG_RETRY_SENT:  rdMux = retryCnt_r;
            REG_BAD_PACKET:  rdMux = badCnt_r;
            REG_DUPLICATE:   rdMux = dupCnt_r;
            default: begin
                if (regAddr[5:4] == REG_FWD_TABLE[5:4]) begin
                    rdMux = fwdTable_r[{regAddr[3:0], 4'h0} +: 16];
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdData_r <= 16'h0000;
        end else if (regRdStrobe) begin
            rdData_r <= rdMux;
        end else begin
            rdData_r <= 16'h0000;
        end
    end

    assign regRdData = rdData_r;

endmodule // rmsl_link

// ===== verification/rmsl_link_asserts.sv
// Purpose: Port checks for rmsl_link
// Assumes: One clock, reset active low
// Notes:   Bound to every rmsl_link instance
`timescale 1ns/1ns
module rmsl_link_asserts
    import rmsl_pkg::*;
(
    input wire logic                         clk,
    input wire logic                         arst_n,
    input wire logic [rmsl_pkg::ADDR_W-1:0]  regAddr,
    input wire logic                         regRdStrobe,
    input wire logic [rmsl_pkg::DATA_W-1:0]  regRdData,
    input wire logic                         rtsOut,
    input wire logic [15:0]                  baudDiv,
    input wire logic                         txReq,
    input wire logic                         txGo,
    input wire logic                         rxValid,
    input wire logic                         rxParErr,
    input wire logic                         rxEnd,
    input wire logic                         rxAck,
    input wire logic                         rxDeliver,
    input wire logic                         rxForward
);
    logic parSeen_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            parSeen_r <= 1'b0;
        end else if (rxEnd) begin
            parSeen_r <= 1'b0;
        end else if (rxValid && rxParErr) begin
            parSeen_r <= 1'b1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    rts_mirror_a: assert property ($past(regRdStrobe) && $past(regAddr) == REG_LINE_STATUS
        && $past(rtsOut) == $past(rtsOut, 2) |-> regRdData[LS_RTS_BIT] == $past(rtsOut))
        else $error("status RTS bit wrong");
    baud_nonzero_a: assert property (baudDiv != 16'h0)
        else $error("bit divider is zero");
    rx_after_end_a: assert property (rxAck || rxDeliver || rxForward |-> $past(rxEnd))
        else $error("receive pulse without end");
    deliver_pulse_a: assert property (rxDeliver |=> !rxDeliver)
        else $error("deliver pulse too long");
    fwd_not_ack_a: assert property (!(rxAck && rxForward))
        else $error("forward and acknowledge together");
    par_err_nack_a: assert property (rxEnd && parSeen_r |=> !rxAck && !rxDeliver && !rxForward)
        else $error("parity error packet accepted");
    rts_after_send_a: assert property ($fell(rtsOut) |-> !$past(txGo))
        else $error("RTS dropped during send");
    pre_gap_a: assert property (txReq && !txGo |=> !txGo)
        else $error("send started without pre delay");
endmodule // rmsl_link_asserts

bind rmsl_link rmsl_link_asserts chk (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
    .regRdStrobe(regRdStrobe), .regRdData(regRdData), .rtsOut(rtsOut), .baudDiv(baudDiv),
    .txReq(txReq), .txGo(txGo), .rxValid(rxValid), .rxParErr(rxParErr), .rxEnd(rxEnd),
    .rxAck(rxAck), .rxDeliver(rxDeliver), .rxForward(rxForward));

// ===== verification/rmsl_modem_model.sv
// Purpose: Half-duplex radio modem facing the link controller
// Assumes: Clear-to-send rises ctsLag + 1 cycles after request-to-send rises
// Notes:   Carrier level follows carrierOn
`timescale 1ns/1ns
module rmsl_modem_model (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       rtsOut,
    input  wire logic [3:0] ctsLag,
    input  wire logic       carrierOn,
    output logic            ctsIn,
    output logic            dcdIn
);
    logic [3:0] waitCnt_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            waitCnt_r <= 4'h0;
            ctsIn     <= 1'b0;
        end else if (!rtsOut) begin
            waitCnt_r <= 4'h0;
            ctsIn     <= 1'b0;
        end else if (waitCnt_r < ctsLag) begin
            waitCnt_r <= waitCnt_r + 4'h1;
        end else begin
            ctsIn <= 1'b1;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dcdIn <= 1'b0;
        end else begin
            dcdIn <= carrierOn;
        end
    end
endmodule // rmsl_modem_model

// ===== verification/rmsl_link_bench.sv
// Purpose: Self-checking bench for rmsl_link
// Assumes: Delay steps shortened by parameters
// Notes:   Random data from a 16-bit LFSR
`timescale 1ns/1ns
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin nFail++; \
    $display("wrong value t=%0t got %h exp %h", $time, (g), (e)); end end
module rmsl_link_bench;
    import rmsl_pkg::*;
    localparam int PC = 4;
    localparam int RC = 10;
    logic clk = 1'b0, arst_n = 1'b0, regWrStrobe = 1'b0, regRdStrobe = 1'b0;
    logic txReq = 1'b0, txRetry = 1'b0, txDone = 1'b0, txNoAck = 1'b0;
    logic rxValid = 1'b0, rxParErr = 1'b0, rxEnd = 1'b0, carrierOn = 1'b0;
    logic ctsIn, dcdIn, rtsOut, irq, parityEven, txGo, rxAck, rxDeliver, rxForward, fwdOn;
    logic [5:0]   regAddr = 6'h00;
    logic [15:0]  regWrData = 16'h0000, rnd = 16'hB859, regRdData, baudDiv, v;
    logic [7:0]   rxByte = 8'h00, own;
    logic [3:0]   ctsLag = 4'h2;
    logic [255:0] tbl;
    int           nFail = 0, cmpCount = 0, lat;
    rmsl_link #(.PRE_CYC(PC), .RTS_CYC(RC)) uut (.clk(clk), .arst_n(arst_n),
        .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
        .regRdStrobe(regRdStrobe), .regRdData(regRdData), .irq(irq), .ctsIn(ctsIn),
        .dcdIn(dcdIn), .rtsOut(rtsOut), .baudDiv(baudDiv), .parityEven(parityEven),
        .txReq(txReq), .txRetry(txRetry), .txGo(txGo), .txDone(txDone), .txNoAck(txNoAck),
        .rxByte(rxByte), .rxValid(rxValid), .rxParErr(rxParErr), .rxEnd(rxEnd),
        .rxAck(rxAck), .rxDeliver(rxDeliver), .rxForward(rxForward));
    rmsl_modem_model modem (.clk(clk), .arst_n(arst_n), .rtsOut(rtsOut), .ctsLag(ctsLag),
        .carrierOn(carrierOn), .ctsIn(ctsIn), .dcdIn(dcdIn));
    always #5 clk = ~clk;
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [2:0] rx_exp(input logic [7:0] d, s, input logic ok, dup);
        logic toMe;
        toMe = ok && d == own;
        return {toMe, ok && !dup && (toMe || d == 8'hFF),
            ok && !dup && fwdOn && d != own && s != own && tbl[d] && tbl[s]};
    endfunction
    task wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        regWrStrobe <= 1'b1;
        regAddr     <= a;
        regWrData   <= d;
        @(posedge clk);
        regWrStrobe <= 1'b0;
    endtask
    task rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge clk);
        regRdStrobe <= 1'b1;
        regAddr     <= a;
        @(posedge clk);
        regRdStrobe <= 1'b0;
        @(negedge clk);
        d = regRdData;
    endtask
    task rc(input logic [5:0] a, input logic [15:0] e);
        logic [15:0] r;
        rd(a, r);
        `CHK(r, e)
    endtask
    task tx(input logic go, rt);
        @(posedge clk);
        txReq   <= go;
        txRetry <= rt;
        txDone  <= !go;
        @(posedge clk);
        {txReq, txRetry, txDone} <= 3'h0;
        lat = go;
        @(negedge clk);
        while ((go ? txGo !== 1'b1 : rtsOut === 1'b1) && lat < 400) begin
            @(negedge clk);
            lat++;
        end
    endtask
    task pkt(input logic [7:0] d, s, b, bad, input logic pe, dup);
        logic [7:0] q[4];
        q = '{d, s, b, 8'h00 - d - s - b + bad};
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            rxValid  <= i < 4;
            rxByte   <= q[i % 4];
            rxParErr <= pe && i == 1;
            rxEnd    <= i == 4;
        end
        @(negedge clk);
        `CHK({rxAck, rxDeliver, rxForward}, rx_exp(d, s, bad == 8'h00 && !pe, dup))
    endtask
    task endSim();
        $display("compares %0d mismatches %0d", cmpCount, nFail);
        if (nFail == 0 && cmpCount > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        nFail++;
        endSim();
    end
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        `CHK(baudDiv, BAUD_DIV_RST)
        `CHK(parityEven, 1'b0)
        rc(REG_CONFIG, 16'h0002);
        rc(REG_NODE_ADDR, 16'h0001);
        rc(REG_FWD_FILE, 16'h0000);
        foreach (v[i]) if (i < 4) rc(i[0] ? REG_BAD_PACKET : REG_DUPLICATE, 16'h0000);
        rc(6'h3F, 16'h0000);
        $display("test reset done");
        rnd = lfsr(rnd);
        own = (rnd[7:0] | 8'h10) == 8'hFF ? 8'hFE : rnd[7:0] | 8'h10;
        wr(REG_NODE_ADDR, {8'h00, own});
        wr(REG_NODE_ADDR, 16'h00FF);
        rc(REG_NODE_ADDR, {8'h00, own});
        wr(REG_FWD_FILE, 16'h0008);
        rc(REG_FWD_FILE, 16'h0000);
        wr(REG_BAUD_DIV, rnd | 16'h0001);
        @(negedge clk);
        `CHK(baudDiv, rnd | 16'h0001)
        wr(REG_CONFIG, 16'h0001);
        @(negedge clk);
        `CHK(parityEven, 1'b1)
        $display("test config done");
        wr(REG_CONFIG, 16'h0000);
        wr(REG_PRE_DELAY, 16'h0002);
        tx(1'b1, 1'b1);
        `CHK(lat >= 2 * PC + 1 && lat <= 2 * PC + 3, 1'b1)
        `CHK(rtsOut, 1'b0)
        tx(1'b0, 1'b0);
        @(posedge clk) txNoAck <= 1'b1;
        @(posedge clk) txNoAck <= 1'b0;
        rc(REG_RETRY_SENT, 16'h0001);
        rc(REG_UNDELIVERED, 16'h0001);
        wr(REG_RETRY_SENT, 16'h1234);
        rc(REG_RETRY_SENT, 16'h0001);
        wr(REG_CONFIG, 16'h0004);
        wr(REG_PRE_DELAY, 16'h0000);
        wr(REG_RTS_ON, 16'h0001);
        for (int k = 0; k < 2; k++) begin
            ctsLag <= k ? 4'hF : 4'h2;
            wr(REG_RTS_OFF, 16'(k));
            tx(1'b1, 1'b0);
            `CHK(ctsIn, 1'b1)
            `CHK(lat > RC + 8 * k, 1'b1)
            rd(REG_LINE_STATUS, v);
            `CHK(v[1:0], 2'h3)
            tx(1'b0, 1'b0);
            `CHK(lat >= k * RC && lat <= k * RC + 3, 1'b1)
        end
        carrierOn <= 1'b1;
        repeat (8) @(posedge clk);
        rc(REG_LINE_STATUS, 16'h0008);
        wr(REG_CONFIG, 16'h0008);
        tx(1'b1, 1'b0);
        `CHK(txGo, 1'b0)
        carrierOn <= 1'b0;
        repeat (8) @(negedge clk);
        `CHK(txGo, 1'b1)
        $display("test transmit done");
        wr(REG_FWD_FILE, 16'h0009);
        wr(REG_FWD_TABLE, 16'h000C);
        fwdOn = 1'b1;
        tbl = 256'h0C;
        rnd = lfsr(rnd);
        pkt(own, 8'h05, rnd[7:0], 8'h00, 1'b0, 1'b0);
        pkt(own, 8'h05, rnd[7:0], 8'h00, 1'b0, 1'b1);
        pkt(own, 8'h05, rnd[15:8], 8'h01, 1'b0, 1'b0);
        pkt(own, 8'h06, rnd[15:8], 8'h00, 1'b1, 1'b0);
        pkt(8'hFF, 8'h07, rnd[7:0], 8'h00, 1'b0, 1'b0);
        pkt(8'h03, 8'h02, rnd[15:8], 8'h00, 1'b0, 1'b0);
        pkt(8'h03, 8'h04, rnd[7:0], 8'h00, 1'b0, 1'b0);
        rc(REG_DUPLICATE, 16'h0001);
        rc(REG_BAD_PACKET, 16'h0002);
        $display("test receive done");
        `CHK(irq, 1'b0)
        rc(REG_INT_STATUS, 16'h000F);
        wr(REG_INT_MASK, 16'h0002);
        @(negedge clk);
        `CHK(irq, 1'b1)
        wr(REG_INT_STATUS, 16'h0002);
        @(negedge clk);
        `CHK(irq, 1'b0)
        rc(REG_INT_STATUS, 16'h000D);
        $display("test interrupt done");
        endSim();
    end
endmodule // rmsl_link_bench
